// File: design/nco_top.sv
// numerically controlled oscillator: 20-bit phase accumulator, double
// buffered increment, fixed duty and pulse frequency output stages.
// assumes oscillator sources arrive synchronous to clk_in and slower than
// half its rate; software reaches the block by byte write strobes.
//
// Behaviour
// - 20-bit accumulator adds buffered increment on each selected input clock rise while enabled
// - additions follow only rising edges of the selected oscillator input
// - carry out of the addition is the raw overflow event
// - accumulator readable and writable as low, high and upper bytes
// - three input clock sources chosen by the clock select field
// - 20-bit increment held in low, high and upper software registers
// - increment registers are readable and writable
// - when enabled, buffers load together on second input edge after low write
// - adder always uses the buffered increment copy
// - when disabled, increment writes reach the buffer at once
// - increment buffers have no software access
// - every overflow sets the interrupt flag
// - mode bit picks pulse stretch or toggle conditioning of the overflow
// - fixed duty mode toggles output on each overflow
// - cleared mode bit means fixed duty mode
// - conditioned output goes to peripherals and optionally a pin
// - pulse mode width is 1 to 128 input periods by 3-bit code
// - polarity bit set makes the output active low
// - select codes 00 fast osc, 01 system osc, 10 logic cell 3, 11 reserved
// - reset clears all registers to zero
`timescale 1ns/100ps
`default_nettype none

module nco_top
   import nco_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // oscillator sources
   input wire logic internal_fast_osc_in,
   input wire logic sys_osc_clk_in,
   input wire logic logic_cell3_output_in,
   // control bits
   input wire logic module_enable_bit_in,
   input wire logic pulse_freq_mode_bit_in,
   input wire logic output_polarity_bit_in,
   input wire logic [nco_pkg::NCO_PWS_W-1:0] pulse_width_select_in,
   input wire logic [1:0] input_clock_select_in,
   input wire logic pin_route_enable_in,
   // software byte writes
   input wire logic [nco_pkg::NCO_BYTE_W-1:0] wr_data_in,
   input wire logic accum_low_byte_wr_in,
   input wire logic accum_high_byte_wr_in,
   input wire logic accum_upper_nibble_wr_in,
   input wire logic increment_low_byte_wr_in,
   input wire logic increment_high_byte_wr_in,
   input wire logic increment_upper_nibble_wr_in,
   input wire logic overflow_irq_flag_clr_in,
   // software read back
   output logic [nco_pkg::NCO_BYTE_W-1:0] accum_low_byte_out,
   output logic [nco_pkg::NCO_BYTE_W-1:0] accum_high_byte_out,
   output logic [nco_pkg::NCO_BYTE_W-1:0] accum_upper_nibble_out,
   output logic [nco_pkg::NCO_BYTE_W-1:0] increment_low_byte_out,
   output logic [nco_pkg::NCO_BYTE_W-1:0] increment_high_byte_out,
   output logic [nco_pkg::NCO_BYTE_W-1:0] increment_upper_nibble_out,
   output logic overflow_irq_flag_out,
   // conditioned output, pin enable and raw carry event
   output logic nco_periph_out,
   output logic nco_pin_out,
   output logic nco_pin_oe_out,
   output logic accum_carry_event_out
);
   import nco_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // state
   logic [NCO_ACC_W-1:0] acc_q, acc_d;
   logic [NCO_ACC_W-1:0] inc_reg_q, inc_reg_d;
   logic [NCO_ACC_W-1:0] inc_buf_q, inc_buf_d;
   logic osc_prev_q;
   logic carry_q;
   logic toggle_q, toggle_d;
   logic pulse_q, pulse_d;
   logic [NCO_PULSE_CNT_W-1:0] pulse_cnt_q, pulse_cnt_d;
   logic flag_q;
   logic [1:0] edge_cnt_q, edge_cnt_d;
   nco_load_state_t load_q, load_d;

   ////////////////////////////////////////////////////////////////////////
   // clock source selection; reserved code gives no edges
   logic osc_sel;
   assign osc_sel = (input_clock_select_in == NCO_CKS_FAST_OSC) ? internal_fast_osc_in :
                    (input_clock_select_in == NCO_CKS_SYS_OSC) ? sys_osc_clk_in :
                    (input_clock_select_in == NCO_CKS_LOGIC_CELL3) ? logic_cell3_output_in :
                    1'b0;

   // rising edge of the chosen source; only these edges advance the block
   logic osc_rise;
   logic step;
   assign osc_rise = osc_sel & ~osc_prev_q;
   assign step = osc_rise & module_enable_bit_in;

   ////////////////////////////////////////////////////////////////////////
   // adder on the buffered copy, carry split off and wrapped
   logic [NCO_ACC_W:0] sum;
   logic carry_now;
   assign sum = {1'b0, acc_q} + {1'b0, inc_buf_q};
   assign carry_now = step & sum[NCO_ACC_W];

   // accumulator next value; a software byte write beats a step
   always_comb begin
      acc_d = acc_q;
      if (step) begin
         acc_d = sum[NCO_ACC_W-1:0];
      end
      if (accum_low_byte_wr_in) begin
         acc_d[NCO_HIGH_LSB-1:NCO_LOW_LSB] = wr_data_in;
      end
      if (accum_high_byte_wr_in) begin
         acc_d[NCO_UPPER_LSB-1:NCO_HIGH_LSB] = wr_data_in;
      end
      if (accum_upper_nibble_wr_in) begin
         acc_d[NCO_ACC_W-1:NCO_UPPER_LSB] = wr_data_in[NCO_UPPER_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // software increment registers
   always_comb begin
      inc_reg_d = inc_reg_q;
      if (increment_low_byte_wr_in) begin
         inc_reg_d[NCO_HIGH_LSB-1:NCO_LOW_LSB] = wr_data_in;
      end
      if (increment_high_byte_wr_in) begin
         inc_reg_d[NCO_UPPER_LSB-1:NCO_HIGH_LSB] = wr_data_in;
      end
      if (increment_upper_nibble_wr_in) begin
         inc_reg_d[NCO_ACC_W-1:NCO_UPPER_LSB] = wr_data_in[NCO_UPPER_W-1:0];
      end
   end

   // buffer load: immediate when disabled, else second input edge after a
   // low write. the buffer is the committed copy, so software relies on
   // writing the low byte last while running.
   logic any_inc_wr;
   assign any_inc_wr = increment_low_byte_wr_in | increment_high_byte_wr_in |
                       increment_upper_nibble_wr_in;

   always_comb begin
      inc_buf_d = inc_buf_q;
      load_d = load_q;
      edge_cnt_d = edge_cnt_q;
      if (!module_enable_bit_in) begin
         load_d = NCO_LOAD_IDLE;
         edge_cnt_d = 2'h0;
         if (any_inc_wr) begin
            inc_buf_d = inc_reg_d;
         end
      end else begin
         unique case (load_q)
            NCO_LOAD_IDLE: begin
               if (increment_low_byte_wr_in) begin
                  load_d = NCO_LOAD_WAIT;
                  edge_cnt_d = 2'h0;
               end
            end
            NCO_LOAD_WAIT: begin
               if (increment_low_byte_wr_in) begin
                  edge_cnt_d = 2'h0; // a fresh low write restarts the wait
               end else if (osc_rise) begin
                  edge_cnt_d = edge_cnt_q + 2'h1;
                  if (edge_cnt_q + 2'h1 == NCO_COMMIT_EDGES) begin
                     inc_buf_d = inc_reg_q;
                     load_d = NCO_LOAD_IDLE;
                     edge_cnt_d = 2'h0;
                  end
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // output conditioning: toggle or pulse stretch
   logic [NCO_PULSE_CNT_W-1:0] pulse_len;
   assign pulse_len = NCO_PULSE_CNT_W'(1) << pulse_width_select_in;

   always_comb begin
      toggle_d = toggle_q;
      pulse_d = pulse_q;
      pulse_cnt_d = pulse_cnt_q;
      if (!module_enable_bit_in) begin
         toggle_d = 1'b0;
         pulse_d = 1'b0;
         pulse_cnt_d = NCO_CNT_RESET;
      end else if (carry_now) begin
         toggle_d = ~toggle_q;
         pulse_d = 1'b1;
         pulse_cnt_d = pulse_len;
      end else if (step && pulse_q) begin
         pulse_cnt_d = pulse_cnt_q - 8'h01;
         pulse_d = (pulse_cnt_q != 8'h01);
      end
   end

   // mode select then polarity
   logic stage_out;
   logic final_out;
   assign stage_out = pulse_freq_mode_bit_in ? pulse_q : toggle_q;
   assign final_out = stage_out ^ output_polarity_bit_in;

   ////////////////////////////////////////////////////////////////////////
   // registers; async reset to zero
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         acc_q <= NCO_ACC_RESET;
         inc_reg_q <= NCO_INC_RESET;
         inc_buf_q <= NCO_INC_RESET;
         load_q <= NCO_LOAD_IDLE;
         edge_cnt_q <= 2'h0;
         osc_prev_q <= 1'b0;
         carry_q <= 1'b0;
         toggle_q <= 1'b0;
         pulse_q <= 1'b0;
         pulse_cnt_q <= NCO_CNT_RESET;
         flag_q <= 1'b0;
      end else begin
         acc_q <= acc_d;
         inc_reg_q <= inc_reg_d;
         inc_buf_q <= inc_buf_d;
         load_q <= load_d;
         edge_cnt_q <= edge_cnt_d;
         osc_prev_q <= osc_sel;
         carry_q <= carry_now;
         toggle_q <= toggle_d;
         pulse_q <= pulse_d;
         pulse_cnt_q <= pulse_cnt_d;
         // set wins over a clear in the same cycle
         flag_q <= carry_now | (flag_q & ~overflow_irq_flag_clr_in);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read back; buffer copy deliberately has no path out
   assign accum_low_byte_out = acc_q[NCO_HIGH_LSB-1:NCO_LOW_LSB];
   assign accum_high_byte_out = acc_q[NCO_UPPER_LSB-1:NCO_HIGH_LSB];
   assign accum_upper_nibble_out = {4'h0, acc_q[NCO_ACC_W-1:NCO_UPPER_LSB]};
   assign increment_low_byte_out = inc_reg_q[NCO_HIGH_LSB-1:NCO_LOW_LSB];
   assign increment_high_byte_out = inc_reg_q[NCO_UPPER_LSB-1:NCO_HIGH_LSB];
   assign increment_upper_nibble_out = {4'h0, inc_reg_q[NCO_ACC_W-1:NCO_UPPER_LSB]};
   assign overflow_irq_flag_out = flag_q;
   assign accum_carry_event_out = carry_q;

   // distribution to peripherals and the optional pin
   assign nco_periph_out = final_out;
   assign nco_pin_out = final_out & pin_route_enable_in;
   assign nco_pin_oe_out = pin_route_enable_in;

endmodule
`default_nettype wire

// File: design/nco_pkg.sv
// package for the numerically controlled oscillator: widths, selects,
// reset values and buffer load timing.
// assumes a single clk_in domain; oscillator sources are sampled levels.
package nco_pkg;

   // accumulator and increment width
   localparam int unsigned NCO_ACC_W = 20;
   localparam int unsigned NCO_BYTE_W = 8;
   localparam int unsigned NCO_UPPER_W = 4;

   // byte field positions inside the 20-bit words
   localparam int unsigned NCO_LOW_LSB = 0;
   localparam int unsigned NCO_HIGH_LSB = 8;
   localparam int unsigned NCO_UPPER_LSB = 16;

   // clock source select codes
   localparam logic [1:0] NCO_CKS_FAST_OSC = 2'h0;
   localparam logic [1:0] NCO_CKS_SYS_OSC = 2'h1;
   localparam logic [1:0] NCO_CKS_LOGIC_CELL3 = 2'h2;
   localparam logic [1:0] NCO_CKS_RESERVED = 2'h3;

   // pulse width select and stretch counter width (up to 128 periods)
   localparam int unsigned NCO_PWS_W = 3;
   localparam int unsigned NCO_PULSE_CNT_W = 8;

   // increment buffer commits on this oscillator edge after a low-byte write
   localparam logic [1:0] NCO_COMMIT_EDGES = 2'h2;

   // reset values
   localparam logic [NCO_ACC_W-1:0] NCO_ACC_RESET = 20'h00000;
   localparam logic [NCO_ACC_W-1:0] NCO_INC_RESET = 20'h00000;
   localparam logic [NCO_PULSE_CNT_W-1:0] NCO_CNT_RESET = 8'h00;

   // buffer load state
   typedef enum logic [1:0] {
      NCO_LOAD_IDLE,
      NCO_LOAD_WAIT
   } nco_load_state_t;

endpackage

// File: bench/nco_top_asserts.sv
// checker for nco_top: output stage, flag and carry relations.
// assumes it is bound into nco_top and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module nco_checker (
   // clock, reset and controls
   input wire logic clk_in, rst_b_in, module_enable_bit_in,
   input wire logic pulse_freq_mode_bit_in, output_polarity_bit_in,
   input wire logic [1:0] input_clock_select_in,
   input wire logic pin_route_enable_in, overflow_irq_flag_clr_in,
   // observed outputs
   input wire logic overflow_irq_flag_out, nco_periph_out,
   input wire logic nco_pin_out, nco_pin_oe_out, accum_carry_event_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   ////////////////////////////////////////
   // enabled toggle-mode edge, then the carry it produced, polarity held
   sequence s_fdc_step;
      module_enable_bit_in && !pulse_freq_mode_bit_in
      ##1 accum_carry_event_out && !pulse_freq_mode_bit_in && $stable(output_polarity_bit_in);
   endsequence
   a_pin_enable: assert property (nco_pin_oe_out == pin_route_enable_in)
      else $error("pin enable differs from route");
   a_pin_gated: assert property (nco_pin_out == (nco_periph_out & pin_route_enable_in))
      else $error("pin level not gated output");
   a_flag_sticky: assert property (overflow_irq_flag_out && !overflow_irq_flag_clr_in |=> overflow_irq_flag_out)
      else $error("flag dropped without clear");
   a_carry_sets_flag: assert property (accum_carry_event_out |-> overflow_irq_flag_out)
      else $error("carry without flag");
   a_flag_cause: assert property ($rose(overflow_irq_flag_out) |-> accum_carry_event_out)
      else $error("flag rose without carry");
   a_carry_single: assert property (accum_carry_event_out |=> !accum_carry_event_out)
      else $error("carry longer than one cycle");
   // an edge seen while off or with no source must not add
   a_no_source_step: assert property (!module_enable_bit_in || input_clock_select_in == 2'h3
      |=> !accum_carry_event_out)
      else $error("carry while stepping refused");
   a_toggle_carry: assert property (s_fdc_step |-> nco_periph_out != $past(nco_periph_out))
      else $error("no toggle on overflow");
   a_idle_polarity: assert property ($past(!module_enable_bit_in)
      |-> nco_periph_out == output_polarity_bit_in)
      else $error("idle level not polarity");
endmodule
bind nco_top nco_checker i_chk(.clk_in, .rst_b_in, .module_enable_bit_in,
   .pulse_freq_mode_bit_in, .output_polarity_bit_in, .input_clock_select_in,
   .pin_route_enable_in, .overflow_irq_flag_clr_in, .overflow_irq_flag_out,
   .nco_periph_out, .nco_pin_out, .nco_pin_oe_out, .accum_carry_event_out);
`default_nettype wire

// File: bench/nco_top_tb.sv
// self-checking bench for nco_top: reset, sources, commit, pulse mode.
// assumes the checker is bound in beside the design.
`timescale 1ns/100ps
`default_nettype none
module nco_top_tb;
   import nco_pkg::*;
   logic clk_in = 1'b0, rst_b_in = 1'b0, en = 1'b0, pfm = 1'b0, pol = 1'b0, rt = 1'b0;
   logic [2:0] src = 3'h0, pws = 3'h0;
   logic [1:0] sel = 2'h0;
   logic [6:0] w = 7'h00;
   logic [7:0] d = 8'h00, al, ah, au, il, ih, iu;
   logic flag, per, pin, oe, car, c;
   int n_errors = 0, samples_checked = 0;
   ////////////////////////////////////////
   nco_top i_dut(.clk_in, .rst_b_in, .internal_fast_osc_in(src[0]),
      .sys_osc_clk_in(src[1]), .logic_cell3_output_in(src[2]),
      .module_enable_bit_in(en), .pulse_freq_mode_bit_in(pfm),
      .output_polarity_bit_in(pol), .pulse_width_select_in(pws),
      .input_clock_select_in(sel), .pin_route_enable_in(rt), .wr_data_in(d),
      .accum_low_byte_wr_in(w[0]), .accum_high_byte_wr_in(w[1]),
      .accum_upper_nibble_wr_in(w[2]), .increment_low_byte_wr_in(w[3]),
      .increment_high_byte_wr_in(w[4]), .increment_upper_nibble_wr_in(w[5]),
      .overflow_irq_flag_clr_in(w[6]), .accum_low_byte_out(al),
      .accum_high_byte_out(ah), .accum_upper_nibble_out(au),
      .increment_low_byte_out(il), .increment_high_byte_out(ih),
      .increment_upper_nibble_out(iu), .overflow_irq_flag_out(flag),
      .nco_periph_out(per), .nco_pin_out(pin), .nco_pin_oe_out(oe),
      .accum_carry_event_out(car));
   initial forever #2.5 clk_in = ~clk_in;
   // compare and count; an unknown never matches
   task automatic chk(input string nm, input logic [23:0] s, e);
      samples_checked++;
      if (s !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   // strobe, then a quiet cycle so strobes never merge
   task automatic wr(input int k, input logic [7:0] v);
      d = v;
      w[k] = 1'b1;
      @(posedge clk_in) #1;
      w = 7'h00;
      @(posedge clk_in) #1;
   endtask
   // upper and high first, low last commits the word
   task automatic setv(input int b, input logic [19:0] v);
      wr(b + 2, {4'h0, v[19:16]});
      wr(b + 1, v[15:8]);
      wr(b, v[7:0]);
   endtask
   // one source period; reserved select gets every source toggling
   task automatic rise();
      src = (sel == 2'h3) ? 3'h7 : 3'h1 << sel;
      @(posedge clk_in) #1;
      c = car;
      src = 3'h0;
      @(posedge clk_in) #1;
   endtask
   task automatic t_reset();
      chk("acc", {au, ah, al}, 24'h0);
      chk("inc", {iu, ih, il}, 24'h0);
      chk("outs", {flag, per, pin, oe, car}, 24'h0);
      $display("test reset done");
   endtask
   task automatic t_sources();
      for (int s = 0; s < 3; s++) begin
         en = 1'b0;
         sel = s[1:0];
         setv(3, 20'h40001);
         chk("inc", {iu, ih, il}, 24'h040001);
         setv(0, 20'hc0000);
         chk("acc", {au, ah, al}, 24'h0c0000);
         en = 1'b1;
         rise();
         chk("acc", {au, ah, al}, 24'h000001);
         chk("carry flag out", {c, flag, per}, 24'h7);
         wr(6, 8'h00);
         chk("flag", flag, 24'h0);
      end
      $display("test sources done");
   endtask
   // the step on the commit edge still adds the old increment
   task automatic t_commit();
      logic [23:0] e[3] = '{24'h10, 24'h20, 24'h40};
      en = 1'b0;
      sel = 2'h0;
      setv(3, 20'h00010);
      setv(0, 20'h00000);
      en = 1'b1;
      wr(3, 8'h20);
      for (int i = 0; i < 3; i++) begin
         rise();
         chk("acc", {au, ah, al}, e[i]);
      end
      sel = 2'h3;
      rise();
      en = 1'b0;
      sel = 2'h0;
      rise();
      chk("acc", {au, ah, al}, 24'h40);
      $display("test commit done");
   endtask
   task automatic t_pulse();
      pfm = 1'b1;
      for (int p = 0; p < 3; p++) begin
         en = 1'b0;
         pws = p[2:0];
         setv(3, 20'h10000);
         setv(0, 20'hf0000);
         en = 1'b1;
         rise();
         chk("pulse", per, 24'h1);
         for (int i = 1; i <= (1 << p); i++) begin
            rise();
            chk("pulse", per, {23'h0, i < (1 << p)});
         end
      end
      en = 1'b0;
      pol = 1'b1;
      rt = 1'b1;
      @(posedge clk_in) #1;
      chk("pol pin oe", {per, pin, oe}, 24'h7);
      $display("test pulse done");
   endtask
   task automatic report_and_stop();
      $display("checked %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // hang guard, far past the roughly 150 cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_in);
      n_errors++;
      report_and_stop();
   end
   initial begin
      repeat (16) @(posedge clk_in);
      #1 rst_b_in = 1'b1;
      @(posedge clk_in) #1;
      t_reset();
      t_sources();
      t_commit();
      t_pulse();
      report_and_stop();
   end
endmodule
`default_nettype wire
